// ==== rtl/cmo_i2c_slave.sv ====
// two-wire serial slave: byte receive, acknowledge and byte send
// assumes pins arrive unsynchronised; sda is open drain, oe low drives
`timescale 1ns/10ps
`default_nettype none
`include "cmo_map.svh"

module cmo_i2c_slave
   import cmo_pkg::*;
#(
   parameter logic [6:0] P_ADDR = `CMO_SLAVE_ADDR
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // bus pins
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_o,
   output logic            o_sda_oe_n,
   // byte side
   input  wire logic [7:0] i_tx_byte,
   output logic [7:0]      o_rx_byte,
   output logic            o_rx_valid,
   output logic            o_rx_first,
   output logic            o_stop
);

   cmo_i2c_reg_t r_ff;
   cmo_i2c_reg_t nxt_r;
   logic         rise;
   logic         fall;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_r          = r_ff;
      nxt_r.rx_valid = 1'b0;
      nxt_r.stop     = 1'b0;
      nxt_r.scl_sy   = {r_ff.scl_sy[1:0], i_scl};
      nxt_r.sda_sy   = {r_ff.sda_sy[1:0], i_sda};
      if (r_ff.scl_sy[1] == r_ff.scl_sy[2]) begin
         nxt_r.scl = r_ff.scl_sy[2];
      end
      if (r_ff.sda_sy[1] == r_ff.sda_sy[2]) begin
         nxt_r.sda = r_ff.sda_sy[2];
      end
      rise = !r_ff.scl && nxt_r.scl;
      fall = r_ff.scl && !nxt_r.scl;
      if (r_ff.scl && nxt_r.scl && r_ff.sda && !nxt_r.sda) begin // RL12
         nxt_r.st       = CMO_I_ADDR;
         nxt_r.bit_n    = 4'h0;
         nxt_r.sda_oe_n = 1'b1;
      end else if (r_ff.scl && nxt_r.scl && !r_ff.sda && nxt_r.sda) begin
         nxt_r.st       = CMO_I_IDLE;
         nxt_r.sda_oe_n = 1'b1;
         nxt_r.stop     = (r_ff.st != CMO_I_IDLE);
      end else if (rise) begin
         case (r_ff.st)
            CMO_I_ADDR, CMO_I_WDATA: begin
               nxt_r.sr    = {r_ff.sr[6:0], nxt_r.sda};
               nxt_r.bit_n = r_ff.bit_n + 4'h1;
            end
            CMO_I_RACK: begin
               nxt_r.nack = nxt_r.sda;
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         case (r_ff.st)
            CMO_I_ADDR: begin
               if (r_ff.bit_n == 4'h8) begin
                  if (r_ff.sr[7:1] == P_ADDR) begin // RL12
                     nxt_r.st       = CMO_I_ACK_A;
                     nxt_r.sda_oe_n = 1'b0;
                     nxt_r.rw       = r_ff.sr[0];
                     nxt_r.first    = 1'b1;
                  end else begin
                     nxt_r.st = CMO_I_IDLE;
                  end
               end
            end
            CMO_I_WDATA: begin
               if (r_ff.bit_n == 4'h8) begin
                  nxt_r.st       = CMO_I_ACK_W;
                  nxt_r.sda_oe_n = 1'b0;
                  nxt_r.rx_byte  = r_ff.sr;
                  nxt_r.rx_valid = 1'b1;
                  nxt_r.rx_first = r_ff.first;
                  nxt_r.first    = 1'b0;
               end
            end
            CMO_I_ACK_A, CMO_I_ACK_W: begin
               if (r_ff.st == CMO_I_ACK_A && r_ff.rw) begin
                  nxt_r.st       = CMO_I_RDATA;
                  nxt_r.sr       = i_tx_byte;
                  nxt_r.sda_oe_n = i_tx_byte[7];
                  nxt_r.bit_n    = 4'h1;
               end else begin
                  nxt_r.st       = CMO_I_WDATA;
                  nxt_r.sda_oe_n = 1'b1;
                  nxt_r.bit_n    = 4'h0;
               end
            end
            CMO_I_RDATA: begin
               if (r_ff.bit_n == 4'h8) begin
                  nxt_r.st       = CMO_I_RACK;
                  nxt_r.sda_oe_n = 1'b1;
               end else begin
                  nxt_r.sda_oe_n = r_ff.sr[3'h7 - r_ff.bit_n[2:0]];
                  nxt_r.bit_n    = r_ff.bit_n + 4'h1;
               end
            end
            CMO_I_RACK: begin
               if (!r_ff.nack) begin
                  nxt_r.st       = CMO_I_RDATA;
                  nxt_r.sr       = i_tx_byte;
                  nxt_r.sda_oe_n = i_tx_byte[7];
                  nxt_r.bit_n    = 4'h1;
               end else begin
                  nxt_r.st = CMO_I_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         r_ff          <= '0;
         r_ff.scl_sy   <= 3'h7;
         r_ff.sda_sy   <= 3'h7;
         r_ff.scl      <= 1'b1;
         r_ff.sda      <= 1'b1;
         r_ff.sda_oe_n <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign o_sda_o    = r_ff.sda_o;
   assign o_sda_oe_n = r_ff.sda_oe_n;
   assign o_rx_byte  = r_ff.rx_byte;
   assign o_rx_valid = r_ff.rx_valid;
   assign o_rx_first = r_ff.rx_first;
   assign o_stop     = r_ff.stop;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_ack_on_match: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL12
      (r_ff.st == CMO_I_ACK_A) |-> !r_ff.sda_oe_n)
      else $error("address acknowledge not driven");
   chk_rx_with_ack: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL12
      r_ff.rx_valid |-> (r_ff.st == CMO_I_ACK_W) && !r_ff.sda_oe_n)
      else $error("received byte without acknowledge");

endmodule : cmo_i2c_slave
`default_nettype wire

// ==== rtl/cmo_map.svh ====
// offsets, field positions, reset values and timing counts of the compass mode block
// assumes inclusion by bare name from package or module files
`ifndef CMO_MAP_SVH
`define CMO_MAP_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define CMO_CLK_HZ          40000000
`define CMO_CLK_NS          25

// ----------------------------------------------------------------
// stored mode configuration
// ----------------------------------------------------------------
`define CMO_CFG_ADDR        8'h04
`define CMO_CFG_RESET       8'h11
`define CMO_CFG_LEVEL_BIT   0
`define CMO_CFG_UE_BIT      1
`define CMO_CFG_UF_BIT      2
`define CMO_CFG_RUN_BIT     4
`define CMO_CFG_RATE_LSB    5
`define CMO_CFG_RATE_MSB    6

// ----------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------
`define CMO_CMD_LEVEL       8'h72
`define CMO_CMD_UE          8'h73
`define CMO_CMD_UF          8'h74
`define CMO_CMD_RUN         8'h50
`define CMO_CMD_STANDBY     8'h51
`define CMO_CMD_SLEEP       8'h52
`define CMO_CMD_WAKE        8'h53
`define CMO_CMD_RESET       8'h54
`define CMO_CMD_CFG_WR      8'h5a
`define CMO_CMD_CFG_RD      8'h5b

// ----------------------------------------------------------------
// serial slave address, 7 bits
// ----------------------------------------------------------------
`define CMO_SLAVE_ADDR      7'h19

// ----------------------------------------------------------------
// update rates and least ready-low times
// ----------------------------------------------------------------
`define CMO_RATE_1_HZ       1
`define CMO_RATE_5_HZ       5
`define CMO_RATE_10_HZ      10
`define CMO_LOW_1_NS        750000
`define CMO_LOW_5_NS        150000
`define CMO_LOW_10_NS       75000
`define CMO_LOW_1_CYC       ((`CMO_LOW_1_NS / `CMO_CLK_NS) + 1)
`define CMO_LOW_5_CYC       ((`CMO_LOW_5_NS / `CMO_CLK_NS) + 1)
`define CMO_LOW_10_CYC      ((`CMO_LOW_10_NS / `CMO_CLK_NS) + 1)

`endif

// ==== rtl/cmo_pkg.sv ====
// types shared by the compass mode block
// assumes cmo_map.svh is on the include path
package cmo_pkg;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CMO_SLEEP, CMO_STANDBY, CMO_RUN} cmo_mode_t;
   typedef enum logic [1:0] {CMO_LEVEL, CMO_UE, CMO_UF} cmo_orient_t;
   typedef enum logic [1:0] {CMO_ARG_NONE, CMO_ARG_WADDR, CMO_ARG_WDATA, CMO_ARG_RADDR} cmo_arg_t;
   typedef enum logic [2:0] {
      CMO_I_IDLE, CMO_I_ADDR, CMO_I_ACK_A, CMO_I_WDATA, CMO_I_ACK_W, CMO_I_RDATA, CMO_I_RACK
   } cmo_i2c_st_t;

   // ----------------------------------------------------------------
   // serial slave state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  scl_sy;
      logic [2:0]  sda_sy;
      logic        scl;
      logic        sda;
      cmo_i2c_st_t st;
      logic [3:0]  bit_n;
      logic [7:0]  sr;
      logic        rw;
      logic        nack;
      logic        first;
      logic        sda_o;
      logic        sda_oe_n;
      logic [7:0]  rx_byte;
      logic        rx_valid;
      logic        rx_first;
      logic        stop;
   } cmo_i2c_reg_t;

   // ----------------------------------------------------------------
   // mode, orientation and ready state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  nv_cfg;
      cmo_mode_t   mode;
      cmo_orient_t orient;
      cmo_orient_t orient_pend;
      logic        pend_valid;
      logic [1:0]  rate;
      logic [25:0] period_cnt;
      logic [15:0] low_cnt;
      logic        waiting;
      logic        loaded;
      logic        result_ready_pin;
      logic        meas_start;
      logic        result_load;
      logic        analog_en;
      logic        forward_z;
      cmo_arg_t    arg;
      logic        addr_ok;
      logic        rd_cfg;
      logic [7:0]  tx_byte;
   } cmo_ctl_reg_t;

endpackage : cmo_pkg

// ==== rtl/cmo_top.sv ====
// compass operating mode, mounting orientation and result-ready logic
// assumes pins asynchronous to i_clk; result path shares i_clk
//
// How it works
// RL1: ready pin rises after results are loaded
// RL2: ready low longer than 750/150/75 us
// RL3: sleep mode switches analog circuitry off
// RL4: standby powered, no measurements, awaits commands
// RL5: run measures continuously at 1/5/10 Hz
// RL6: mode settings held in stored register 04
// RL7: level, upright edge, upright front orientations
// RL8: upright orientations pick X or Z forward
// RL9: commands 72/73/74 set orientation, store untouched
// RL10: stored orientation takes effect after reset
// RL11: host corrects odd mountings by deviation
// RL12: commands arrive over two-wire serial slave
// RL13: temporary orientation applies at next measurement
`timescale 1ns/10ps
`default_nettype none
`include "cmo_map.svh"

module cmo_top
   import cmo_pkg::*;
#(
   parameter int P_PERIOD_1  = `CMO_CLK_HZ / `CMO_RATE_1_HZ,
   parameter int P_PERIOD_5  = `CMO_CLK_HZ / `CMO_RATE_5_HZ,
   parameter int P_PERIOD_10 = `CMO_CLK_HZ / `CMO_RATE_10_HZ,
   parameter int P_LOW_1     = `CMO_LOW_1_CYC,
   parameter int P_LOW_5     = `CMO_LOW_5_CYC,
   parameter int P_LOW_10    = `CMO_LOW_10_CYC
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // serial bus pins
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_o,
   output logic            o_sda_oe_n,
   // measurement path
   input  wire logic       i_result_done,
   output logic            o_meas_start,
   output logic            o_result_load,
   output logic            o_analog_en,
   // orientation
   output logic [1:0]      o_orient,
   output logic            o_forward_z,
   // ready pin
   output logic            o_result_ready_pin
);

   cmo_ctl_reg_t r_ff;
   cmo_ctl_reg_t nxt_r;
   logic [7:0]   rx_byte;
   logic         rx_valid;
   logic         rx_first;
   logic         start_now;
   logic         cfg_wr_evt;
   logic         temp_evt;

   // ----------------------------------------------------------------
   // config decode helpers
   // ----------------------------------------------------------------
   function automatic cmo_orient_t cfg_orient(input logic [7:0] c);
      if (c[`CMO_CFG_UF_BIT]) begin
         return CMO_UF;
      end else if (c[`CMO_CFG_UE_BIT]) begin
         return CMO_UE;
      end
      return CMO_LEVEL;
   endfunction : cfg_orient

   function automatic cmo_mode_t cfg_mode(input logic [7:0] c);
      return c[`CMO_CFG_RUN_BIT] ? CMO_RUN : CMO_STANDBY;
   endfunction : cfg_mode

   function automatic logic [25:0] period_of(input logic [1:0] rt);
      case (rt)
         2'h1:    return 26'(P_PERIOD_5 - 1);
         2'h2:    return 26'(P_PERIOD_10 - 1);
         default: return 26'(P_PERIOD_1 - 1);
      endcase
   endfunction : period_of

   function automatic logic [15:0] low_of(input logic [1:0] rt);
      case (rt)
         2'h1:    return 16'(P_LOW_5);
         2'h2:    return 16'(P_LOW_10);
         default: return 16'(P_LOW_1);
      endcase
   endfunction : low_of

   // ----------------------------------------------------------------
   // serial slave
   // ----------------------------------------------------------------
   cmo_i2c_slave u_i2c (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_scl      (i_scl),
      .i_sda      (i_sda),
      .o_sda_o    (o_sda_o),
      .o_sda_oe_n (o_sda_oe_n),
      .i_tx_byte  (r_ff.tx_byte),
      .o_rx_byte  (rx_byte),
      .o_rx_valid (rx_valid),
      .o_rx_first (rx_first),
      .o_stop     ()
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_r             = r_ff;
      nxt_r.meas_start  = 1'b0;
      nxt_r.result_load = 1'b0;
      cfg_wr_evt        = 1'b0;
      temp_evt          = 1'b0;
      start_now         = (r_ff.mode == CMO_RUN) && (r_ff.period_cnt == 26'h0);
      // commands
      if (rx_valid && rx_first) begin // RL12
         nxt_r.arg    = CMO_ARG_NONE;
         nxt_r.rd_cfg = 1'b0;
         case (rx_byte)
            `CMO_CMD_LEVEL, `CMO_CMD_UE, `CMO_CMD_UF: begin // RL9
               temp_evt          = 1'b1;
               nxt_r.pend_valid  = 1'b1;
               nxt_r.orient_pend = (rx_byte == `CMO_CMD_UE) ? CMO_UE :
                                   (rx_byte == `CMO_CMD_UF) ? CMO_UF : CMO_LEVEL; // RL7
            end
            `CMO_CMD_RUN: begin // RL5
               nxt_r.mode       = CMO_RUN;
               nxt_r.period_cnt = 26'h0;
            end
            `CMO_CMD_STANDBY, `CMO_CMD_WAKE: begin // RL4
               nxt_r.mode = CMO_STANDBY;
            end
            `CMO_CMD_SLEEP: begin // RL3
               nxt_r.mode = CMO_SLEEP;
            end
            `CMO_CMD_RESET: begin // RL10
               nxt_r.orient     = cfg_orient(r_ff.nv_cfg);
               nxt_r.mode       = cfg_mode(r_ff.nv_cfg);
               nxt_r.rate       = r_ff.nv_cfg[`CMO_CFG_RATE_MSB:`CMO_CFG_RATE_LSB];
               nxt_r.pend_valid = 1'b0;
               nxt_r.period_cnt = 26'h0;
            end
            `CMO_CMD_CFG_WR: begin
               nxt_r.arg = CMO_ARG_WADDR;
            end
            `CMO_CMD_CFG_RD: begin
               nxt_r.arg = CMO_ARG_RADDR;
            end
            default: begin
            end
         endcase
      end else if (rx_valid) begin
         case (r_ff.arg)
            CMO_ARG_WADDR: begin
               nxt_r.addr_ok = (rx_byte == `CMO_CFG_ADDR);
               nxt_r.arg     = CMO_ARG_WDATA;
            end
            CMO_ARG_WDATA: begin
               if (r_ff.addr_ok) begin // RL6
                  cfg_wr_evt   = 1'b1;
                  nxt_r.nv_cfg = rx_byte;
               end
               nxt_r.arg = CMO_ARG_NONE;
            end
            CMO_ARG_RADDR: begin
               nxt_r.rd_cfg = (rx_byte == `CMO_CFG_ADDR);
               nxt_r.arg    = CMO_ARG_NONE;
            end
            default: begin
            end
         endcase
      end
      // measurement cycle
      if (r_ff.low_cnt != 16'h0) begin
         nxt_r.low_cnt = r_ff.low_cnt - 16'h1;
      end
      if (r_ff.mode == CMO_RUN && !start_now) begin // RL5
         nxt_r.period_cnt = r_ff.period_cnt - 26'h1;
      end
      if (i_result_done && r_ff.waiting) begin
         nxt_r.result_load = 1'b1;
         nxt_r.waiting     = 1'b0;
         nxt_r.loaded      = 1'b1;
      end
      if (start_now) begin // RL5
         nxt_r.period_cnt = period_of(r_ff.rate);
         nxt_r.meas_start = 1'b1;
         nxt_r.waiting    = 1'b1;
         nxt_r.loaded     = i_result_done && r_ff.waiting;
         nxt_r.result_ready_pin       = 1'b0;
         nxt_r.low_cnt    = low_of(r_ff.rate); // RL2
         if (r_ff.pend_valid && nxt_r.pend_valid) begin // RL13
            nxt_r.orient     = r_ff.orient_pend;
            nxt_r.pend_valid = temp_evt;
         end
      end else if (r_ff.loaded && r_ff.low_cnt == 16'h0) begin // RL1
         nxt_r.result_ready_pin   = 1'b1;
         nxt_r.loaded = 1'b0;
      end
      nxt_r.analog_en = (nxt_r.mode != CMO_SLEEP); // RL3
      nxt_r.forward_z = (nxt_r.orient == CMO_UF); // RL8
      nxt_r.tx_byte   = nxt_r.rd_cfg ? nxt_r.nv_cfg :
                        {nxt_r.result_ready_pin, nxt_r.pend_valid, nxt_r.mode, nxt_r.rate, nxt_r.orient};
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         r_ff           <= '0;
         r_ff.nv_cfg    <= `CMO_CFG_RESET;
         r_ff.mode      <= cfg_mode(`CMO_CFG_RESET);
         r_ff.orient    <= cfg_orient(`CMO_CFG_RESET);
         r_ff.rate      <= 2'(`CMO_CFG_RESET >> `CMO_CFG_RATE_LSB);
         r_ff.analog_en <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign o_meas_start       = r_ff.meas_start;
   assign o_result_load      = r_ff.result_load;
   assign o_analog_en        = r_ff.analog_en;
   assign o_orient           = r_ff.orient;
   assign o_forward_z        = r_ff.forward_z;
   assign o_result_ready_pin = r_ff.result_ready_pin;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [15:0] low_seen_ff;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         low_seen_ff <= 16'h0;
      end else if (r_ff.result_ready_pin) begin
         low_seen_ff <= 16'h0;
      end else if (low_seen_ff != 16'hffff) begin
         low_seen_ff <= low_seen_ff + 16'h1;
      end
   end

   sequence s_loaded_then_rise;
      r_ff.loaded && r_ff.low_cnt == 16'h0 && !start_now ##1 r_ff.result_ready_pin;
   endsequence

   chk_ready_after_load: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL1
      $rose(r_ff.result_ready_pin) |-> $past(r_ff.loaded) && !r_ff.loaded)
      else $error("ready rose without loaded results");
   chk_ready_rise_seq: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL1
      s_loaded_then_rise |-> !r_ff.loaded)
      else $error("ready rise sequence broken");
   chk_low_time_min: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL2
      $rose(r_ff.result_ready_pin) |-> low_seen_ff >= low_of(r_ff.rate))
      else $error("ready low time too short");
   chk_sleep_analog: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL3
      (r_ff.mode == CMO_SLEEP) |-> !r_ff.analog_en)
      else $error("analog powered in sleep");
   chk_no_meas_idle: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL4
      (r_ff.mode != CMO_RUN) |=> !r_ff.meas_start)
      else $error("measurement outside run");
   chk_run_period: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL5
      start_now |=> r_ff.meas_start ##1 !r_ff.meas_start)
      else $error("run cycle did not start");
   chk_cfg_store: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL6
      cfg_wr_evt |=> r_ff.nv_cfg == $past(rx_byte))
      else $error("stored config not written");
   chk_temp_keeps: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL9
      temp_evt |=> $stable(r_ff.nv_cfg) && r_ff.pend_valid)
      else $error("temporary orientation touched store");
   chk_perm_delay: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL10
      cfg_wr_evt && !start_now |=> $stable(r_ff.orient))
      else $error("stored orientation applied early");
   chk_forward_axis: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL8
      (r_ff.orient == CMO_UE) |-> !r_ff.forward_z)
      else $error("upright edge forward axis wrong");

endmodule : cmo_top
`default_nettype wire

// ==== verif/cmo_host.sv ====
// two-wire bus master model standing in for the host controller
// assumes the bench resolves open-drain sda with a pull-up
`timescale 1ns/10ps
`default_nettype none

module cmo_host (
   // bus lines
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda,
   // acknowledge record
   output logic      o_ok
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
      o_ok  = 1'b1;
   end

   // ----------------------------------------------------------------
   // bus phases, half period of 8 clocks
   // ----------------------------------------------------------------
   task automatic hp;
      repeat (8) @(negedge i_clk);
   endtask : hp

   task automatic xfer(input logic [7:0] tx, input logic ack_chk, output logic [7:0] rx);
      logic [8:0] b;
      logic [8:0] r;
      b = {tx, 1'b1};
      r = '0;
      for (int i = 8; i >= 0; i--) begin
         o_sda = b[i];
         hp;
         o_scl = 1'b1;
         hp;
         r = {r[7:0], i_sda};
         o_scl = 1'b0;
         @(negedge i_clk);
      end
      rx = r[8:1];
      if (ack_chk && r[0] !== 1'b0) o_ok = 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] q[$]);
      logic [7:0] r;
      o_sda = 1'b0;
      hp;
      o_scl = 1'b0;
      hp;
      foreach (q[i]) xfer(q[i], 1'b1, r);
      o_sda = 1'b0;
      hp;
      o_scl = 1'b1;
      hp;
      o_sda = 1'b1;
      hp;
   endtask : wr

   task automatic rd(output logic [7:0] v);
      logic [7:0] r;
      o_sda = 1'b0;
      hp;
      o_scl = 1'b0;
      hp;
      xfer(8'h33, 1'b1, r);
      xfer(8'hff, 1'b0, v);
      o_sda = 1'b0;
      hp;
      o_scl = 1'b1;
      hp;
      o_sda = 1'b1;
      hp;
   endtask : rd
endmodule : cmo_host

`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench of the compass mode block
// assumes shortened period and low-time parameters
`timescale 1ns/10ps
`default_nettype none

module tb;
   import cmo_pkg::*;
   logic        i_clk, i_resetn, scl, hsda, sda_o, sda_oe_n;
   logic        meas, load, aen, fz, rdy, ok;
   logic        i_result_done = 1'b0, rdy_p = 1'b0, loaded = 1'b0;
   logic [1:0]  ori;
   logic [7:0]  v;
   logic [7:0]  ocmd [3] = '{8'h74, 8'h73, 8'h72};
   logic [31:0] cnt, plow;
   logic [31:0] rs = 32'h79d8, lowc = 0, dly = 0;
   int          n_fail, cmp_count;
   wire logic   sda;
   assign sda = hsda & (sda_oe_n | sda_o);

   cmo_top #(.P_PERIOD_1(400), .P_PERIOD_5(200), .P_PERIOD_10(100),
      .P_LOW_1(30), .P_LOW_10(6)) dut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
      .o_sda_oe_n(sda_oe_n), .i_result_done(i_result_done), .o_meas_start(meas),
      .o_result_load(load), .o_analog_en(aen), .o_orient(ori), .o_forward_z(fz),
      .o_result_ready_pin(rdy));
   cmo_host host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda), .o_ok(ok));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   function automatic logic [2:0] exp_or(input logic [7:0] c);
      return {c == 8'h74, c[1:0] - 2'd2};
   endfunction : exp_or

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", nm, e, s);
      end
   endtask : chk

   task automatic per(input logic [31:0] e);
      logic [31:0] n;
      n = 0;
      while (meas !== 1'b1 && n < 3000) begin
         @(negedge i_clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (meas !== 1'b1 && n < 3000);
      chk("period", e, n);
   endtask : per

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // clock, result path and ready monitor
   // ----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   always @(negedge i_clk) begin
      if (meas === 1'b1) begin
         loaded = 1'b0;
         rs = lfsr(rs);
         dly = rs[3:0] + 1;
      end
      i_result_done = (dly == 1);
      if (dly != 0) dly--;
      if (load === 1'b1) loaded = 1'b1;
      if (i_resetn && rdy === 1'b1 && rdy_p === 1'b0) begin
         chk("ready after load", 1, loaded);
         chk("ready low long", 1, lowc >= plow);
      end
      lowc = (rdy === 1'b1) ? 0 : lowc + 1;
      rdy_p = rdy;
   end

   initial begin
      #(25 * 60000);
      n_fail++;
      summarize;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      i_resetn = 1'b0;
      plow = 30;
      n_fail = 0;
      cmp_count = 0;
      repeat (6) @(negedge i_clk);
      i_resetn = 1'b1;
      chk("orientation", 0, {fz, ori});
      chk("analog", 1, aen);
      per(400);
      host.wr('{8'h32, 8'h51});
      cnt = 0;
      repeat (600) begin
         @(negedge i_clk);
         cnt += meas;
      end
      chk("standby starts", 0, cnt);
      chk("standby analog", 1, aen);
      host.wr('{8'h32, 8'h52});
      chk("sleep analog", 0, aen);
      host.wr('{8'h32, 8'h53});
      chk("wake analog", 1, aen);
      host.wr('{8'h32, 8'h50});
      foreach (ocmd[i]) begin
         v = ocmd[i];
         host.wr('{8'h32, v});
         per(400);
         chk("temp orientation", exp_or(v), {fz, ori});
      end
      host.wr('{8'h32, 8'h5b, 8'h04});
      host.rd(v);
      chk("store kept", 8'h11, v);
      host.wr('{8'h32, 8'h5a, 8'h04, 8'h54});
      host.wr('{8'h32, 8'h5a, 8'h05, 8'h00});
      per(400);
      chk("orientation held", 0, {fz, ori});
      host.wr('{8'h32, 8'h5b, 8'h04});
      host.rd(v);
      chk("stored config", 8'h54, v);
      plow = 6;
      host.wr('{8'h32, 8'h54});
      per(100);
      chk("stored orientation", 3'b110, {fz, ori});
      host.rd(v);
      chk("status", 8'h2a, v & 8'h7f);
      chk("acknowledges", 1, ok);
      summarize;
   end
endmodule : tb

`default_nettype wire
